/* File: verilog/access_code_correlator_map.vh */
// constants for the access code correlator: timing counts, command codes, sizes
// assumes the includer runs on a 250 MHz system clock
`ifndef ACCESS_CODE_CORRELATOR_MAP_VH
`define ACCESS_CODE_CORRELATOR_MAP_VH

// clock and sample rates
`define CLK_RATE_KHZ 250000
`define SAMPLE_RATE_KHZ 8000
`define OVERSAMPLE 8
`define PHASE_W 18

// correlator sizes
`define CODE_BITS 64
`define BUF_LEN (`CODE_BITS * `OVERSAMPLE)
`define CENTER_TAP 4
`define SCORE_W 7

// timing: idle hold before the system load starts
`define IDLE_NS 2000
`define IDLE_CYCLES ((`IDLE_NS * (`CLK_RATE_KHZ / 1000)) / 1000)
`define IDLE_CNT_W 10

// frame/slot counter: half slot period counted in samples
`define HALF_SLOT_NS 312500
`define HALF_SLOT_SAMPLES (`HALF_SLOT_NS / (1000000 / `SAMPLE_RATE_KHZ))
`define SLOT_PHASE_W 12
`define SLOT_CNT_W 28
`define SYNC_END_SAMPLES 576
`define WINDOW_SAMPLES 640

// command codes
`define CMD_W 4
`define CMD_SRX_CONT 4'h0
`define CMD_SRX_WIN 4'h1
`define CMD_STX 4'h2
`define CMD_MRX 4'h3
`define CMD_MTX 4'h4
`define CMD_MASTER_CLK 4'h5
`define CMD_SLAVE_CLK 4'h6
`define CMD_POWER_DOWN 4'h7
`define CMD_SRX_WIN_ENC 4'h8
`define CMD_STX_ENC 4'h9
`define CMD_MRX_ENC 4'ha
`define CMD_MTX_ENC 4'hb

`endif

/* File: verilog/pin_sync.v */
// two flip-flop synchroniser for a group of pin inputs
// assumes the inputs are asynchronous to i_clk_sys
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
    parameter WIDTH = 2
) (
    // clock and reset
    input wire i_clk_sys,
    input wire i_nrst,
    // pins and synchronised levels
    input wire [WIDTH-1:0] i_pin,
    output reg [WIDTH-1:0] o_level
);

    reg [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            meta <= {WIDTH{1'b0}};
            o_level <= {WIDTH{1'b0}};
        end else begin
            meta <= i_pin;
            o_level <= meta;
        end
    end

endmodule // pin_sync

`default_nettype wire

/* File: verilog/access_code_correlator.v */
// receive correlator: 8x sampling, access code correlation, slot resync, idle/load
// assumes code, threshold and commands come from same-clock link logic; rx and load pins are async
`timescale 1ns/1ns
`default_nettype none
`include "access_code_correlator_map.vh"

module access_code_correlator (
    // clock and reset
    input wire i_clk_sys,
    input wire i_nrst,
    // radio and controller pins
    input wire i_rx_data,
    input wire i_load_req_n,
    // access code and threshold from the controller link
    input wire i_code_load,
    input wire [`CODE_BITS-1:0] i_code_data,
    input wire [`SCORE_W-1:0] i_threshold,
    // commands
    input wire i_cmd_valid,
    input wire [`CMD_W-1:0] i_cmd,
    // status
    output reg o_idle,
    output reg o_sysload_start,
    output reg o_correlation_match_flag,
    output reg [`SCORE_W-1:0] o_correlation_match_flag_max,
    output reg o_rx_active,
    output reg o_tx_active,
    output reg o_encrypt_en,
    output reg o_slave_clock,
    output reg o_power_down,
    output reg o_half_slot_tick,
    output reg [`SLOT_CNT_W-1:0] o_slot_count
);

    localparam ST_IDLE = 2'b00;
    localparam ST_WAIT = 2'b01;
    localparam ST_RUN = 2'b10;

    // counts cut to their counter widths on purpose; every value fits its field
    localparam integer PHASE_WRAP_I = `CLK_RATE_KHZ - `SAMPLE_RATE_KHZ;
    localparam integer PHASE_STEP_I = `SAMPLE_RATE_KHZ;
    localparam integer IDLE_LAST_I = `IDLE_CYCLES - 1;
    localparam integer WIN_LAST_I = `WINDOW_SAMPLES - 1;
    localparam integer SLOT_LAST_I = `HALF_SLOT_SAMPLES - 1;
    localparam integer SYNC_END_I = `SYNC_END_SAMPLES;
    localparam [`PHASE_W-1:0] PHASE_WRAP = PHASE_WRAP_I[`PHASE_W-1:0];
    localparam [`PHASE_W-1:0] PHASE_STEP = PHASE_STEP_I[`PHASE_W-1:0];
    localparam [`IDLE_CNT_W-1:0] IDLE_LAST = IDLE_LAST_I[`IDLE_CNT_W-1:0];
    localparam [`SLOT_PHASE_W-1:0] WIN_LAST = WIN_LAST_I[`SLOT_PHASE_W-1:0];
    localparam [`SLOT_PHASE_W-1:0] SLOT_LAST = SLOT_LAST_I[`SLOT_PHASE_W-1:0];
    localparam [`SLOT_PHASE_W-1:0] SYNC_END = SYNC_END_I[`SLOT_PHASE_W-1:0];

    wire rx_sample;
    wire load_req;
    wire load_req_n;
    wire rx_cmd_code;
    reg load_req_n_d;
    reg [1:0] state;
    reg [`IDLE_CNT_W-1:0] idle_cnt;
    reg [`PHASE_W-1:0] phase_acc;
    reg sample_stb;
    reg [`BUF_LEN-1:0] sample_buf;
    reg [`CODE_BITS-1:0] access_code_register;
    reg [`SCORE_W-1:0] match_threshold_register;
    reg windowed;
    reg [`SLOT_PHASE_W-1:0] window_cnt;
    reg [`SLOT_PHASE_W-1:0] slot_phase;
    reg [`SCORE_W-1:0] score;
    wire [`CODE_BITS-1:0] bit_match;
    integer i;

    pin_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_pin({i_rx_data, ~i_load_req_n}),
        .o_level({rx_sample, load_req})
    );

    // request synchronised active high: cleared flops read as no request, so no false edge after reset
    assign load_req_n = ~load_req;

    // only receive commands open a fresh correlation window
    assign rx_cmd_code = (i_cmd == `CMD_SRX_CONT) || (i_cmd == `CMD_SRX_WIN) || (i_cmd == `CMD_MRX) ||
                         (i_cmd == `CMD_SRX_WIN_ENC) || (i_cmd == `CMD_MRX_ENC);

    // fractional rate divider: 250 MHz down to an average 8 MHz strobe
    always @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            phase_acc <= {`PHASE_W{1'b0}};
            sample_stb <= 1'b0;
        end else if (phase_acc >= PHASE_WRAP) begin
            phase_acc <= phase_acc - PHASE_WRAP;
            sample_stb <= 1'b1;
        end else begin
            phase_acc <= phase_acc + PHASE_STEP;
            sample_stb <= 1'b0;
        end
    end

    // one tap per code bit at the centre of its eight samples
    genvar g;
    generate
        for (g = 0; g < `CODE_BITS; g = g + 1) begin : g_tap
            assign bit_match[g] = ~(sample_buf[g * `OVERSAMPLE + `CENTER_TAP] ^ access_code_register[g]);
        end
    endgenerate

    // agreement count across the whole sync word at once
    always @* begin
        score = {`SCORE_W{1'b0}};
        for (i = 0; i < `CODE_BITS; i = i + 1) begin
            score = score + {{(`SCORE_W-1){1'b0}}, bit_match[i]};
        end
    end

    // code and threshold are taken on any i_code_load, also during a running receive
    always @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            access_code_register <= {`CODE_BITS{1'b0}};
            match_threshold_register <= {`SCORE_W{1'b1}};
        end else if (i_code_load) begin
            access_code_register <= i_code_data;
            match_threshold_register <= i_threshold;
        end
    end

    // control: idle on load request, wait, then pulse system load and run commands
    always @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            load_req_n_d <= 1'b1;
            state <= ST_IDLE;
            idle_cnt <= {`IDLE_CNT_W{1'b0}};
            o_idle <= 1'b1;
            o_sysload_start <= 1'b0;
            o_rx_active <= 1'b0;
            o_tx_active <= 1'b0;
            o_encrypt_en <= 1'b0;
            o_slave_clock <= 1'b0;
            o_power_down <= 1'b0;
            windowed <= 1'b0;
        end else begin
            load_req_n_d <= load_req_n;
            o_sysload_start <= 1'b0;
            // low level holds idle; link logic dropped at once, long hold is the controller's job
            if (!load_req_n) begin
                state <= ST_IDLE;
                o_idle <= 1'b1;
                o_rx_active <= 1'b0;
                o_tx_active <= 1'b0;
                o_encrypt_en <= 1'b0;
                o_power_down <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        if (!load_req_n_d) begin
                            state <= ST_WAIT;
                            idle_cnt <= {`IDLE_CNT_W{1'b0}};
                        end
                    end
                    ST_WAIT: begin
                        idle_cnt <= idle_cnt + 1'b1;
                        if (idle_cnt == IDLE_LAST) begin
                            state <= ST_RUN;
                            o_sysload_start <= 1'b1;
                            o_idle <= 1'b0;
                        end
                    end
                    ST_RUN: begin
                        if (i_cmd_valid) begin
                            o_rx_active <= 1'b0;
                            o_tx_active <= 1'b0;
                            o_encrypt_en <= 1'b0;
                            o_power_down <= 1'b0;
                            windowed <= 1'b0;
                            case (i_cmd)
                                `CMD_SRX_CONT, `CMD_MRX: o_rx_active <= 1'b1;
                                `CMD_SRX_WIN: begin
                                    o_rx_active <= 1'b1;
                                    windowed <= 1'b1;
                                end
                                `CMD_STX, `CMD_MTX: o_tx_active <= 1'b1;
                                `CMD_MASTER_CLK: o_slave_clock <= 1'b0;
                                `CMD_SLAVE_CLK: o_slave_clock <= 1'b1;
                                `CMD_POWER_DOWN: o_power_down <= 1'b1;
                                `CMD_SRX_WIN_ENC: begin
                                    o_rx_active <= 1'b1;
                                    windowed <= 1'b1;
                                    o_encrypt_en <= 1'b1;
                                end
                                `CMD_MRX_ENC: begin
                                    o_rx_active <= 1'b1;
                                    o_encrypt_en <= 1'b1;
                                end
                                `CMD_STX_ENC, `CMD_MTX_ENC: begin
                                    o_tx_active <= 1'b1;
                                    o_encrypt_en <= 1'b1;
                                end
                                default: ;
                            endcase
                        end else if (windowed && o_rx_active && sample_stb &&
                                     window_cnt == WIN_LAST) begin
                            o_rx_active <= 1'b0; // window closes
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    // sample buffer, window count, running maximum and match flag
    always @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            sample_buf <= {`BUF_LEN{1'b0}};
            window_cnt <= {`SLOT_PHASE_W{1'b0}};
            o_correlation_match_flag_max <= {`SCORE_W{1'b0}};
            o_correlation_match_flag <= 1'b1;
        end else if (i_cmd_valid && state == ST_RUN && load_req_n && rx_cmd_code) begin
            // fresh receive: forget old maximum; sample_buf is kept, so samples from before this window can still match
            window_cnt <= {`SLOT_PHASE_W{1'b0}};
            o_correlation_match_flag_max <= {`SCORE_W{1'b0}};
            o_correlation_match_flag <= 1'b1;
        end else if (o_rx_active && sample_stb) begin
            sample_buf <= {sample_buf[`BUF_LEN-2:0], rx_sample};
            window_cnt <= window_cnt + 1'b1;
            if (score > o_correlation_match_flag_max) begin
                o_correlation_match_flag_max <= score;
            end
            if (score > match_threshold_register || o_correlation_match_flag_max > match_threshold_register) begin
                o_correlation_match_flag <= 1'b0;
            end
        end
    end

    // frame/slot counter in half slots; slave resyncs to the sample that matched
    always @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            slot_phase <= {`SLOT_PHASE_W{1'b0}};
            o_slot_count <= {`SLOT_CNT_W{1'b0}};
            o_half_slot_tick <= 1'b0;
        end else begin
            o_half_slot_tick <= 1'b0;
            if (o_slave_clock && o_rx_active && sample_stb && o_correlation_match_flag &&
                score > match_threshold_register) begin
                slot_phase <= SYNC_END;
            end else if (sample_stb) begin
                if (slot_phase == SLOT_LAST) begin
                    slot_phase <= {`SLOT_PHASE_W{1'b0}};
                    o_slot_count <= o_slot_count + 1'b1;
                    o_half_slot_tick <= 1'b1;
                end else begin
                    slot_phase <= slot_phase + 1'b1;
                end
            end
        end
    end

endmodule // access_code_correlator

`default_nettype wire

/* File: verification/radio_model.sv */
// radio side: sends a 64 bit word msb first at 1 Mbps on the receive pin
// assumes the 250 MHz system clock; outside a frame the pin toggles
`timescale 1ns/1ns
`default_nettype none
module radio_model (
    input wire logic i_clk_sys,
    input wire logic i_send,
    input wire logic [63:0] i_word,
    output logic o_rx
);
    int bitn = -1;
    int cnt = 0;
    initial o_rx = 1'b0;
    // 250 cycles per symbol; toggling avoids a stale level looking like data
    always @(posedge i_clk_sys) begin
        if (bitn < 0 && i_send)
            bitn = 63;
        if (bitn >= 0) begin
            o_rx <= i_word[bitn];
            cnt = cnt + 1;
            if (cnt == 250) begin
                cnt = 0;
                bitn = bitn - 1;
            end
        end else
            o_rx <= ~o_rx;
    end
endmodule // radio_model
`default_nettype wire

/* File: verification/access_code_correlator_asserts.sv */
// checker for the correlator: idle/load timing, commands, match flag
// assumes a bind onto the top module, one clock domain
`timescale 1ns/1ns
`default_nettype none
`include "access_code_correlator_map.vh"
module acc_checker (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_load_req_n,
    input wire logic i_code_load,
    input wire logic [`SCORE_W-1:0] i_threshold,
    input wire logic i_cmd_valid,
    input wire logic [`CMD_W-1:0] i_cmd,
    input wire logic o_idle,
    input wire logic o_sysload_start,
    input wire logic o_correlation_match_flag,
    input wire logic [`SCORE_W-1:0] o_correlation_match_flag_max,
    input wire logic o_rx_active,
    input wire logic o_power_down
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    logic [`SCORE_W-1:0] thr;
    wire run_cmd = i_cmd_valid && !o_idle && i_load_req_n;
    wire rx_cmd = run_cmd && (i_cmd inside {4'h0, 4'h1, 4'h3, 4'h8, 4'ha});
    // copy of the captured threshold, so the flag is judged against it
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst)
            thr <= 7'h7f;
        else if (i_code_load)
            thr <= i_threshold;
    end
    idle_on_load_a: assert property ((!i_load_req_n) [*4] |-> o_idle) else $error("not idle");
    load_delay_a: assert property ($rose(i_load_req_n) |-> ##[499:506] o_sysload_start)
        else $error("load start late");
    sysload_pulse_a: assert property (o_sysload_start |=> !o_sysload_start && !o_idle)
        else $error("load pulse long");
    sysload_exit_a: assert property (o_sysload_start |-> !o_idle && $past(o_idle))
        else $error("load start not from idle");
    rx_cmd_clear_a: assert property (rx_cmd |=> o_correlation_match_flag && o_correlation_match_flag_max == 7'h0)
        else $error("receive start wrong");
    flag_clear_a: assert property ($fell(o_correlation_match_flag) |-> o_correlation_match_flag_max > thr && $past(o_rx_active))
        else $error("flag cleared below threshold");
    flag_set_a: assert property ($rose(o_correlation_match_flag) |-> $past(rx_cmd))
        else $error("flag set without receive");
    max_keep_a: assert property (o_correlation_match_flag_max < $past(o_correlation_match_flag_max) |-> o_correlation_match_flag_max == 7'h0)
        else $error("maximum dropped");
    power_down_a: assert property (run_cmd && i_cmd == 4'h7 |=> o_power_down && !o_rx_active)
        else $error("power down wrong");
    cover property ($fell(o_correlation_match_flag));
    cover property (o_sysload_start);
    cover property (run_cmd && i_cmd == 4'h7);
endmodule // acc_checker
bind access_code_correlator acc_checker u_chk (.i_clk_sys, .i_nrst, .i_load_req_n, .i_code_load, .i_threshold,
    .i_cmd_valid, .i_cmd, .o_idle, .o_sysload_start, .o_correlation_match_flag, .o_correlation_match_flag_max, .o_rx_active,
    .o_power_down);
`default_nettype wire

/* File: verification/tb.sv */
// testbench for the correlator: reset, load sequence, commands, match
// assumes the radio model drives the receive pin
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; $display("unexpected %0t %h %h", $time, a, e); end end
module tb;
    localparam logic [63:0] WORD = 64'hd3a5_0f96_c3e1_7b28;
    logic i_clk_sys = 1'b0;
    logic i_nrst = 1'b0;
    logic i_load_req_n = 1'b0;
    logic i_code_load = 1'b0;
    logic [63:0] i_code_data = 64'h0;
    logic [6:0] i_threshold = 7'h0;
    logic i_cmd_valid = 1'b0;
    logic [3:0] i_cmd = 4'h0;
    logic send = 1'b0;
    wire rx, idle, sl, flag, rxa, txa, enc, sc, pd, tick;
    wire [27:0] scnt;
    wire [6:0] cmax;
    int n_fail = 0;
    int check_count = 0;
    int i;
    // expected {rx, tx, encrypt, power down} per command code
    logic [3:0] exp_f [12] = '{4'h8, 4'h8, 4'h4, 4'h8, 4'h4, 4'h0, 4'h0, 4'h1, 4'ha, 4'h6, 4'ha, 4'h6};
    access_code_correlator dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_rx_data(rx), .i_load_req_n(i_load_req_n),
        .i_code_load(i_code_load), .i_code_data(i_code_data), .i_threshold(i_threshold), .i_cmd_valid(i_cmd_valid),
        .i_cmd(i_cmd), .o_idle(idle), .o_sysload_start(sl), .o_correlation_match_flag(flag), .o_correlation_match_flag_max(cmax),
        .o_rx_active(rxa), .o_tx_active(txa), .o_encrypt_en(enc), .o_slave_clock(sc), .o_power_down(pd),
        .o_half_slot_tick(tick), .o_slot_count(scnt));
    radio_model u_radio (.i_clk_sys(i_clk_sys), .i_send(send), .i_word(WORD), .o_rx(rx));
    initial forever #2 i_clk_sys = ~i_clk_sys;
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // strobe one command, then look at the flags once they settle
    task automatic do_cmd(input logic [3:0] c);
        @(posedge i_clk_sys);
        i_cmd_valid <= 1'b1;
        i_cmd <= c;
        @(posedge i_clk_sys);
        i_cmd_valid <= 1'b0;
        @(negedge i_clk_sys);
    endtask
    task automatic test_load;
        int n;
        do_cmd(4'h0);
        `CHK(rxa, 1'b0)
        repeat (500) @(posedge i_clk_sys);
        i_load_req_n <= 1'b1;
        for (n = 0; n < 700 && sl !== 1'b1; n++)
            @(negedge i_clk_sys);
        `CHK(n >= 500 && n <= 506, 1'b1)
        `CHK(idle, 1'b0)
        if (n == 700)
            finish_test();
        @(negedge i_clk_sys);
        `CHK(sl, 1'b0)
        $display("load done");
    endtask
    task automatic test_cmds;
        for (i = 0; i < 12; i++) begin
            do_cmd(i[3:0]);
            `CHK({rxa, txa, enc, pd}, exp_f[i])
            if (i == 5 || i == 6)
                `CHK(sc, ~i[0])
            if (exp_f[i][3])
                `CHK({flag, cmax}, 8'h80)
        end
        $display("commands done");
    endtask
    task automatic test_match;
        int n;
        logic [27:0] c0;
        @(posedge i_clk_sys);
        i_code_load <= 1'b1;
        i_code_data <= WORD;
        i_threshold <= 7'h3c;
        @(posedge i_clk_sys);
        i_code_load <= 1'b0;
        do_cmd(4'h6);
        do_cmd(4'h0);
        @(posedge i_clk_sys);
        send <= 1'b1;
        @(posedge i_clk_sys);
        send <= 1'b0;
        for (n = 0; n < 20000 && flag !== 1'b0; n++)
            @(negedge i_clk_sys);
        `CHK(flag, 1'b0)
        `CHK(cmax > 7'h3c, 1'b1)
        if (n == 20000)
            finish_test();
        // slave resync puts the match at the sync word end: next half slot 1924 samples later
        c0 = scnt;
        for (n = 0; n < 61000 && tick !== 1'b1; n++)
            @(negedge i_clk_sys);
        `CHK(n >= 60093 && n <= 60157, 1'b1)
        `CHK(scnt, c0 + 28'h1)
        if (n == 61000)
            finish_test();
        do_cmd(4'h1);
        `CHK({flag, cmax}, 8'h80)
        // windowed receive closes itself after 640 samples, 20000 cycles give or take one sample
        for (n = 0; n < 21000 && rxa !== 1'b0; n++)
            @(negedge i_clk_sys);
        `CHK(n >= 19968 && n <= 20032, 1'b1)
        if (n == 21000)
            finish_test();
        $display("match done");
    endtask
    initial begin
        repeat (5) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        @(negedge i_clk_sys);
        `CHK({idle, flag, rxa, txa, sl, cmax}, 12'hc00)
        test_load();
        test_cmds();
        test_match();
        finish_test();
    end
endmodule // tb
`default_nettype wire
